//--- rtl/lieq_top.sv
`timescale 1ns/100ps

// Summary of operation
// (RL1) bit 4 of error count register enables integrity error counting
// (RL2) 4-bit lock-loss threshold in bits 3:0, reset 3, counter on pixel clock
// (RL3) lane0, lane1 clock bits and control word errors all feed the counter
// (RL4) counting enabled: lock drops when error count reaches the threshold
// (RL5) counting disabled: lock drops on the first integrity error
// (RL6) reverse SPI: miso always driven if policy 0, else tri-state when deselected
// (RL7) polarity 0: drive on falling, sample rising; 1: the reverse
// (RL8) mode 000 normal, 001/010/011 fast gpio 1/2/4 pins, 100/101 reserved
// (RL9) mode 110 forward SPI forwarding, 111 reverse SPI forwarding
// (RL10) coarse manual field bits 7:5, reset 3, gives eq setting bits 5:3 in bypass
// (RL11) fine manual field bits 3:1 gives eq setting bits 2:0 in bypass
// (RL12) second-port target set: bypass register writes go to port one
// (RL13) second-port target set: config register applies to port one
// (RL14) floor enabled by pin or register: adaptation starts from 4-bit level
// (RL15) bypass bit stops adaptation and applies the 6-bit manual setting
module lieq_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic lane0_embedded_clock_err,
  input wire logic lane1_embedded_clock_err,
  input wire logic control_word_stream_err,
  input wire logic link_locked,
  output logic rx_lock,
  output logic lock_drop,
  input wire logic spi_sclk,
  input wire logic spi_ss_n,
  input wire logic spi_mosi,
  input wire logic spi_tx_bit,
  output logic spi_miso_o,
  output logic spi_miso_oe,
  output logic spi_mosi_bit,
  output logic spi_sample,
  output logic spi_drive,
  output logic [2:0] fast_back_channel_select,
  output logic fast_gpio_en,
  output logic fwd_spi_en,
  output logic rev_spi_en,
  input wire logic [5:0] auto_eq_value_p0,
  input wire logic [5:0] auto_eq_value_p1,
  input wire logic floor_pin,
  output logic [5:0] eq_setting_p0,
  output logic [5:0] eq_setting_p1,
  output logic auto_eq_en_p0,
  output logic auto_eq_en_p1,
  output logic auto_eq_floor_en,
  output logic [3:0] auto_eq_start_level_p0,
  output logic [3:0] auto_eq_start_level_p1,
  output logic irq
);
  import lieq_pkg::*;

  // ==========================================================
  // pin synchronisers: stage one is read only by stage two
  logic [7:0] sync1_r;
  logic [7:0] sync2_r;
  logic sclk_d_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_r <= 8'h00;
      sync2_r <= 8'h00;
      sclk_d_r <= 1'b0;
    end else begin
      sync1_r <= {lane0_embedded_clock_err, floor_pin, spi_mosi, spi_ss_n, spi_sclk,
                  link_locked, control_word_stream_err, lane1_embedded_clock_err};
      sync2_r <= sync1_r;
      sclk_d_r <= sync2_r[3];
    end
  end

  logic l0_err_s, l1_err_s, cw_err_s, locked_s, sclk_s, ss_n_s, mosi_s, floor_pin_s;
  assign l0_err_s = sync2_r[7];
  assign l1_err_s = sync2_r[0];
  assign cw_err_s = sync2_r[1];
  assign locked_s = sync2_r[2];
  assign sclk_s = sync2_r[3];
  assign ss_n_s = sync2_r[4];
  assign mosi_s = sync2_r[5];
  assign floor_pin_s = sync2_r[6];

  // ==========================================================
  // ahb-lite slave: zero wait, always OKAY, write lands in data phase
  logic wr_pend_r, wr_pend_nxt;
  logic [7:0] wr_idx_r, wr_idx_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic rd_take;
  logic [7:0] a_idx;

  assign a_idx = haddr[LIEQ_ADDR_MSB:LIEQ_ADDR_LSB];
  assign rd_take = hsel & htrans[1] & hready & ~hwrite;

  // ==========================================================
  // register state
  logic [7:0] err_ctrl_r, err_ctrl_nxt;
  logic [7:0] fbc_ctrl_r, fbc_ctrl_nxt;
  logic [7:0] eq_byp_r [2], eq_byp_nxt [2];
  logic [7:0] eq_cfg_r [2], eq_cfg_nxt [2];
  logic [7:0] target_r, target_nxt;
  logic [1:0] irq_stat_r, irq_stat_nxt;
  logic [1:0] irq_mask_r, irq_mask_nxt;
  logic wr_act;
  logic [7:0] wdat;
  logic port_sel;
  logic [1:0] evt;

  assign wr_act = wr_pend_r;
  assign wdat = hwdata[7:0];
  assign port_sel = target_r[LIEQ_TARGET_BIT];

  // ==========================================================
  // lock and integrity counter state
  lieq_lock_type lock_st_r, lock_st_nxt;
  logic [3:0] err_cnt_r, err_cnt_nxt;
  logic drop;
  logic [1:0] n_err;
  logic [4:0] cnt_sum;
  logic [3:0] thr;
  logic cnt_en;

  // errors from all three sources are counted in the same pixel cycle
  assign n_err = 2'(l0_err_s) + 2'(l1_err_s) + 2'(cw_err_s); // [RL3]
  assign cnt_sum = 5'(err_cnt_r) + 5'(n_err);
  assign thr = err_ctrl_r[LIEQ_THR_MSB:LIEQ_THR_LSB]; // [RL2]
  assign cnt_en = err_ctrl_r[LIEQ_ERR_EN_BIT]; // [RL1]

  always_comb begin
    lock_st_nxt = lock_st_r;
    err_cnt_nxt = err_cnt_r;
    drop = 1'b0;
    unique case (lock_st_r)
      LK_WAIT: begin
        err_cnt_nxt = 4'h0;
        if (locked_s) begin
          lock_st_nxt = LK_LOCKED;
        end
      end
      LK_LOCKED: begin
        if (!locked_s) begin
          lock_st_nxt = LK_WAIT;
        end else if (n_err != 2'h0) begin
          if (!cnt_en) begin
            drop = 1'b1; // [RL5]
          end else if (cnt_sum >= 5'(thr)) begin
            drop = 1'b1; // [RL4]
          end else begin
            err_cnt_nxt = cnt_sum[3:0]; // [RL2]
          end
          if (drop) begin
            lock_st_nxt = LK_LOST;
            err_cnt_nxt = 4'h0;
          end
        end
      end
      LK_LOST: begin
        // relock only after the front end itself lost and regained lock
        if (!locked_s) begin
          lock_st_nxt = LK_WAIT;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lock_st_r <= LK_WAIT;
      err_cnt_r <= 4'h0;
    end else begin
      lock_st_r <= lock_st_nxt;
      err_cnt_r <= err_cnt_nxt;
    end
  end

  assign evt[LIEQ_IRQ_LOST_BIT] = drop;
  assign evt[LIEQ_IRQ_ERR_BIT] = (lock_st_r == LK_LOCKED) && (n_err != 2'h0);

  // ==========================================================
  // register writes; the second-port target picks the eq bank
  always_comb begin
    err_ctrl_nxt = err_ctrl_r;
    fbc_ctrl_nxt = fbc_ctrl_r;
    eq_byp_nxt = eq_byp_r;
    eq_cfg_nxt = eq_cfg_r;
    target_nxt = target_r;
    irq_mask_nxt = irq_mask_r;
    irq_stat_nxt = irq_stat_r;
    if (wr_act) begin
      unique case (wr_idx_r)
        LIEQ_IDX_ERR_CTRL: err_ctrl_nxt = wdat; // [RL1] [RL2]
        LIEQ_IDX_FBC_CTRL: fbc_ctrl_nxt = wdat; // [RL8]
        LIEQ_IDX_EQ_BYP: eq_byp_nxt[port_sel] = wdat; // [RL12]
        LIEQ_IDX_EQ_CFG: eq_cfg_nxt[port_sel] = wdat; // [RL13]
        LIEQ_IDX_TARGET: target_nxt = {6'h00, wdat[1:0]};
        LIEQ_IDX_IRQ_MASK: irq_mask_nxt = wdat[1:0];
        LIEQ_IDX_IRQ_STAT: irq_stat_nxt = irq_stat_r & ~wdat[1:0];
        default: ;
      endcase
    end
    // a new event beats a clear in the same cycle
    irq_stat_nxt = irq_stat_nxt | evt;
  end

  // read data is built from next values so a read right behind a write sees it
  always_comb begin
    hrdata_nxt = hrdata_r;
    wr_pend_nxt = hsel & htrans[1] & hready & hwrite;
    wr_idx_nxt = hready ? a_idx : wr_idx_r;
    if (rd_take) begin
      unique case (a_idx)
        LIEQ_IDX_ERR_CTRL: hrdata_nxt = {24'h000000, err_ctrl_nxt};
        LIEQ_IDX_FBC_CTRL: hrdata_nxt = {24'h000000, fbc_ctrl_nxt};
        LIEQ_IDX_EQ_BYP: hrdata_nxt = {24'h000000, eq_byp_nxt[target_nxt[0]]};
        LIEQ_IDX_EQ_CFG: hrdata_nxt = {24'h000000, eq_cfg_nxt[target_nxt[0]]};
        LIEQ_IDX_TARGET: hrdata_nxt = {24'h000000, target_nxt};
        LIEQ_IDX_IRQ_STAT: hrdata_nxt = {30'h0, irq_stat_nxt};
        LIEQ_IDX_IRQ_MASK: hrdata_nxt = {30'h0, irq_mask_nxt};
        LIEQ_IDX_LINK_STAT: hrdata_nxt = {26'h0, err_cnt_r,
                                          (lock_st_r == LK_LOST),
                                          (lock_st_r == LK_LOCKED)};
        default: hrdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      err_ctrl_r <= LIEQ_ERR_CTRL_RST; // [RL2]
      fbc_ctrl_r <= LIEQ_FBC_CTRL_RST;
      eq_byp_r[0] <= LIEQ_EQ_BYP_RST; // [RL10]
      eq_byp_r[1] <= LIEQ_EQ_BYP_RST;
      eq_cfg_r[0] <= LIEQ_EQ_CFG_RST;
      eq_cfg_r[1] <= LIEQ_EQ_CFG_RST;
      target_r <= LIEQ_TARGET_RST;
      irq_stat_r <= 2'h0;
      irq_mask_r <= LIEQ_IRQ_MASK_RST[1:0];
      wr_pend_r <= 1'b0;
      wr_idx_r <= 8'h00;
      hrdata_r <= 32'h00000000;
    end else begin
      err_ctrl_r <= err_ctrl_nxt;
      fbc_ctrl_r <= fbc_ctrl_nxt;
      eq_byp_r <= eq_byp_nxt;
      eq_cfg_r <= eq_cfg_nxt;
      target_r <= target_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      wr_pend_r <= wr_pend_nxt;
      wr_idx_r <= wr_idx_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end

  // ==========================================================
  // back-channel mode decode; reserved codes fall back to plain framing
  lieq_fbc_type mode;
  logic gpio_nxt, fwd_nxt, rev_nxt;
  assign mode = lieq_fbc_type'(fbc_ctrl_r[LIEQ_MODE_MSB:LIEQ_MODE_LSB]);

  always_comb begin
    gpio_nxt = 1'b0;
    fwd_nxt = 1'b0;
    rev_nxt = 1'b0;
    unique case (mode)
      FBC_NORMAL, FBC_RSVD4, FBC_RSVD5: ; // [RL8]
      FBC_GPIO1, FBC_GPIO2, FBC_GPIO4: gpio_nxt = 1'b1; // [RL8]
      FBC_FWD_SPI: fwd_nxt = 1'b1; // [RL9]
      FBC_REV_SPI: rev_nxt = 1'b1; // [RL9]
    endcase
  end

  // ==========================================================
  // tunnelled spi pins in reverse spi mode
  logic sclk_rise, sclk_fall, drv_edge, smp_edge, ss_act;
  logic miso_nxt, miso_oe_nxt, mosi_nxt;

  assign sclk_rise = sclk_s & ~sclk_d_r;
  assign sclk_fall = ~sclk_s & sclk_d_r;
  assign ss_act = ~ss_n_s;
  // polarity picks which edge launches and which captures
  assign drv_edge = fbc_ctrl_r[LIEQ_CPOL_BIT] ? sclk_rise : sclk_fall; // [RL7]
  assign smp_edge = fbc_ctrl_r[LIEQ_CPOL_BIT] ? sclk_fall : sclk_rise; // [RL7]

  always_comb begin
    miso_nxt = spi_miso_o;
    mosi_nxt = spi_mosi_bit;
    miso_oe_nxt = 1'b0;
    if (rev_nxt) begin
      // bused slaves must release the line when not selected
      miso_oe_nxt = ~fbc_ctrl_r[LIEQ_MISO_MODE_BIT] | ss_act; // [RL6]
      if (ss_act && drv_edge) begin
        miso_nxt = spi_tx_bit; // [RL7]
      end
      if (ss_act && smp_edge) begin
        mosi_nxt = mosi_s; // [RL7]
      end
    end
  end

  // ==========================================================
  // equalizer outputs per port
  logic [5:0] eq_set_nxt [2];
  logic [3:0] start_nxt [2];
  logic [1:0] aeq_en_nxt;
  logic floor_nxt;

  assign floor_nxt = floor_pin_s | target_r[LIEQ_FLOOR_EN_BIT]; // [RL14]

  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++) begin : g_port
      always_comb begin
        aeq_en_nxt[gp] = ~eq_byp_r[gp][LIEQ_BYPASS_BIT]; // [RL15]
        start_nxt[gp] = eq_cfg_r[gp][LIEQ_START_MSB:LIEQ_START_LSB]; // [RL14]
        if (eq_byp_r[gp][LIEQ_BYPASS_BIT]) begin
          eq_set_nxt[gp] = {eq_byp_r[gp][LIEQ_COARSE_MSB:LIEQ_COARSE_LSB], // [RL10]
                            eq_byp_r[gp][LIEQ_FINE_MSB:LIEQ_FINE_LSB]}; // [RL11] [RL15]
        end else begin
          eq_set_nxt[gp] = (gp == 0) ? auto_eq_value_p0 : auto_eq_value_p1;
        end
      end
    end
  endgenerate

  // ==========================================================
  // output flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_lock <= 1'b0;
      lock_drop <= 1'b0;
      spi_miso_o <= 1'b0;
      spi_miso_oe <= 1'b0;
      spi_mosi_bit <= 1'b0;
      spi_sample <= 1'b0;
      spi_drive <= 1'b0;
      fast_back_channel_select <= 3'h0;
      fast_gpio_en <= 1'b0;
      fwd_spi_en <= 1'b0;
      rev_spi_en <= 1'b0;
      eq_setting_p0 <= 6'h00;
      eq_setting_p1 <= 6'h00;
      auto_eq_en_p0 <= 1'b0;
      auto_eq_en_p1 <= 1'b0;
      auto_eq_floor_en <= 1'b0;
      auto_eq_start_level_p0 <= 4'h0;
      auto_eq_start_level_p1 <= 4'h0;
      irq <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      rx_lock <= (lock_st_nxt == LK_LOCKED); // [RL4] [RL5]
      lock_drop <= drop;
      spi_miso_o <= miso_nxt;
      spi_miso_oe <= miso_oe_nxt; // [RL6]
      spi_mosi_bit <= mosi_nxt;
      spi_sample <= rev_nxt & ss_act & smp_edge;
      spi_drive <= rev_nxt & ss_act & drv_edge;
      fast_back_channel_select <= fbc_ctrl_r[LIEQ_MODE_MSB:LIEQ_MODE_LSB]; // [RL8]
      fast_gpio_en <= gpio_nxt;
      fwd_spi_en <= fwd_nxt;
      rev_spi_en <= rev_nxt;
      eq_setting_p0 <= eq_set_nxt[0];
      eq_setting_p1 <= eq_set_nxt[1];
      auto_eq_en_p0 <= aeq_en_nxt[0];
      auto_eq_en_p1 <= aeq_en_nxt[1];
      auto_eq_floor_en <= floor_nxt;
      auto_eq_start_level_p0 <= start_nxt[0];
      auto_eq_start_level_p1 <= start_nxt[1];
      irq <= |(irq_stat_nxt & irq_mask_nxt);
      hreadyout <= 1'b1; // bus answers are fixed: never stalls
      hresp <= 1'b0; // never errors
    end
  end

  assign hrdata = hrdata_r;

endmodule

//--- rtl/lieq_pkg.sv
package lieq_pkg;

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] LIEQ_IDX_ERR_CTRL = 8'h41;
  localparam logic [7:0] LIEQ_IDX_FBC_CTRL = 8'h43;
  localparam logic [7:0] LIEQ_IDX_EQ_BYP = 8'h44;
  localparam logic [7:0] LIEQ_IDX_EQ_CFG = 8'h45;
  localparam logic [7:0] LIEQ_IDX_TARGET = 8'h46;
  localparam logic [7:0] LIEQ_IDX_IRQ_STAT = 8'h48;
  localparam logic [7:0] LIEQ_IDX_IRQ_MASK = 8'h49;
  localparam logic [7:0] LIEQ_IDX_LINK_STAT = 8'h4A;
  localparam int LIEQ_ADDR_LSB = 2;
  localparam int LIEQ_ADDR_MSB = 9;

  // ==========================================================
  // field positions
  localparam int LIEQ_ERR_EN_BIT = 4;
  localparam int LIEQ_THR_MSB = 3;
  localparam int LIEQ_THR_LSB = 0;
  localparam int LIEQ_MISO_MODE_BIT = 4;
  localparam int LIEQ_CPOL_BIT = 3;
  localparam int LIEQ_MODE_MSB = 2;
  localparam int LIEQ_MODE_LSB = 0;
  localparam int LIEQ_COARSE_MSB = 7;
  localparam int LIEQ_COARSE_LSB = 5;
  localparam int LIEQ_FINE_MSB = 3;
  localparam int LIEQ_FINE_LSB = 1;
  localparam int LIEQ_BYPASS_BIT = 0;
  localparam int LIEQ_START_MSB = 3;
  localparam int LIEQ_START_LSB = 0;
  localparam int LIEQ_TARGET_BIT = 0;
  localparam int LIEQ_FLOOR_EN_BIT = 1;
  localparam int LIEQ_IRQ_LOST_BIT = 0;
  localparam int LIEQ_IRQ_ERR_BIT = 1;

  // ==========================================================
  // reset values
  localparam logic [7:0] LIEQ_ERR_CTRL_RST = 8'h03;
  localparam logic [7:0] LIEQ_FBC_CTRL_RST = 8'h00;
  localparam logic [7:0] LIEQ_EQ_BYP_RST = 8'h60;
  localparam logic [7:0] LIEQ_EQ_CFG_RST = 8'h08;
  localparam logic [7:0] LIEQ_TARGET_RST = 8'h00;
  localparam logic [7:0] LIEQ_IRQ_MASK_RST = 8'h00;

  // ==========================================================
  // back-channel modes and lock states
  typedef enum logic [2:0] {
    FBC_NORMAL, FBC_GPIO1, FBC_GPIO2, FBC_GPIO4,
    FBC_RSVD4, FBC_RSVD5, FBC_FWD_SPI, FBC_REV_SPI
  } lieq_fbc_type;

  typedef enum logic [1:0] {LK_WAIT, LK_LOCKED, LK_LOST} lieq_lock_type;

endpackage

//--- verification/lieq_monitor.sv
`timescale 1ns/100ps

// ==========================================================
// pin-level checker for the link and equalizer control block
module lieq_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic lane0_embedded_clock_err,
  input wire logic lane1_embedded_clock_err,
  input wire logic control_word_stream_err,
  input wire logic rx_lock,
  input wire logic lock_drop,
  input wire logic spi_miso_oe,
  input wire logic [2:0] fast_back_channel_select,
  input wire logic fast_gpio_en,
  input wire logic fwd_spi_en,
  input wire logic rev_spi_en,
  input wire logic [5:0] auto_eq_value_p0,
  input wire logic [5:0] auto_eq_value_p1,
  input wire logic [5:0] eq_setting_p0,
  input wire logic [5:0] eq_setting_p1,
  input wire logic auto_eq_en_p0,
  input wire logic auto_eq_en_p1
);
  logic any_err;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // any error pin; two sync flops plus the lock_drop output flop give three edges
  assign any_err = lane0_embedded_clock_err | lane1_embedded_clock_err |
                   control_word_stream_err;

  // ==========================================================
  // assertions
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or answered with an error");
  AST_GPIO_MODES: assert property (
    fast_gpio_en == (fast_back_channel_select inside {3'h1, 3'h2, 3'h3}))
    else $error("fast gpio enable does not follow mode field");
  AST_FWD_SPI: assert property (fwd_spi_en == (fast_back_channel_select == 3'h6))
    else $error("forward spi enable does not follow mode field");
  AST_REV_SPI: assert property (rev_spi_en == (fast_back_channel_select == 3'h7))
    else $error("reverse spi enable does not follow mode field");
  AST_MISO_QUIET: assert property (!rev_spi_en && !$past(rev_spi_en) |-> !spi_miso_oe)
    else $error("miso driven outside reverse spi mode");
  AST_DROP_WAS_LOCKED: assert property (lock_drop |-> !rx_lock && $past(rx_lock))
    else $error("lock drop without a held lock");
  AST_DROP_CAUSE: assert property (lock_drop |-> $past(any_err, 3))
    else $error("lock drop not three edges after an error");
  AST_AUTO_EQ_P0: assert property (
    auto_eq_en_p0 && $past(auto_eq_en_p0) && $past(auto_eq_en_p0, 2)
    |-> eq_setting_p0 == $past(auto_eq_value_p0))
    else $error("port zero setting not from adaptive result");
  AST_AUTO_EQ_P1: assert property (
    auto_eq_en_p1 && $past(auto_eq_en_p1) && $past(auto_eq_en_p1, 2)
    |-> eq_setting_p1 == $past(auto_eq_value_p1))
    else $error("port one setting not from adaptive result");
endmodule

bind lieq_top lieq_monitor mon (
  .clk(clk), .rst(rst), .hreadyout(hreadyout), .hresp(hresp),
  .lane0_embedded_clock_err(lane0_embedded_clock_err),
  .lane1_embedded_clock_err(lane1_embedded_clock_err),
  .control_word_stream_err(control_word_stream_err),
  .rx_lock(rx_lock), .lock_drop(lock_drop), .spi_miso_oe(spi_miso_oe),
  .fast_back_channel_select(fast_back_channel_select), .fast_gpio_en(fast_gpio_en),
  .fwd_spi_en(fwd_spi_en), .rev_spi_en(rev_spi_en),
  .auto_eq_value_p0(auto_eq_value_p0), .auto_eq_value_p1(auto_eq_value_p1),
  .eq_setting_p0(eq_setting_p0), .eq_setting_p1(eq_setting_p1),
  .auto_eq_en_p0(auto_eq_en_p0), .auto_eq_en_p1(auto_eq_en_p1)
);

//--- verification/lieq_serializer_model.sv
`timescale 1ns/100ps

// ==========================================================
// far-end serializer: link lock and integrity error pulses
module lieq_serializer_model (
  input wire logic clk,
  output logic link_locked,
  output logic lane0_err,
  output logic lane1_err,
  output logic cw_err
);
  // link starts untrained and error free
  initial begin
    link_locked = 1'b0;
    lane0_err = 1'b0;
    lane1_err = 1'b0;
    cw_err = 1'b0;
  end

  // retrain: a low phase first, since a lost lock waits for it
  task automatic relock();
    @(posedge clk);
    link_locked <= 1'b0;
    repeat (4) @(posedge clk);
    link_locked <= 1'b1;
    @(posedge clk);
  endtask

  // one-cycle error: 0 lane0 clock bit, 1 lane1 clock bit, 2 control words
  task automatic send_err(input int which);
    @(posedge clk);
    lane0_err <= (which == 0);
    lane1_err <= (which == 1);
    cw_err <= (which == 2);
    @(posedge clk);
    lane0_err <= 1'b0;
    lane1_err <= 1'b0;
    cw_err <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
endmodule

//--- verification/lieq_tb_top.sv
`timescale 1ns/100ps

// ==========================================================
// testbench top
module lieq_tb_top;
  import lieq_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic spi_sclk = 1'b0, spi_ss_n = 1'b1, spi_mosi = 1'b0, spi_tx_bit = 1'b0;
  logic floor_pin = 1'b0;
  logic [5:0] auto_eq_value_p0 = 6'h15, auto_eq_value_p1 = 6'h2C;
  logic l0_err, l1_err, cw_err, link_locked, hreadyout, hresp, rx_lock, lock_drop;
  logic spi_miso_o, spi_miso_oe, spi_mosi_bit, fast_gpio_en, fwd_spi_en, rev_spi_en, irq;
  logic spi_sample, spi_drive;
  logic auto_eq_floor_en, auto_eq_en_p0, auto_eq_en_p1;
  logic [31:0] hrdata, rd;
  logic [2:0] fast_back_channel_select;
  logic [5:0] eq_setting_p0, eq_setting_p1;
  logic [3:0] auto_eq_start_level_p0, auto_eq_start_level_p1;
  int fails = 0, compares = 0, drops = 0, samples = 0, drives = 0;

  always #5 clk = ~clk;
  // drop pulses last one cycle, so count them as they pass
  always @(posedge clk) if (lock_drop === 1'b1) drops++;
  always @(posedge clk) if (spi_sample === 1'b1) samples++;
  always @(posedge clk) if (spi_drive === 1'b1) drives++;

  lieq_top dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .lane0_embedded_clock_err(l0_err), .lane1_embedded_clock_err(l1_err),
    .control_word_stream_err(cw_err), .link_locked(link_locked), .rx_lock(rx_lock),
    .lock_drop(lock_drop), .spi_sclk(spi_sclk), .spi_ss_n(spi_ss_n), .spi_mosi(spi_mosi),
    .spi_tx_bit(spi_tx_bit), .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe),
    .spi_mosi_bit(spi_mosi_bit), .spi_sample(spi_sample), .spi_drive(spi_drive),
    .fast_back_channel_select(fast_back_channel_select), .fast_gpio_en(fast_gpio_en),
    .fwd_spi_en(fwd_spi_en), .rev_spi_en(rev_spi_en), .auto_eq_value_p0(auto_eq_value_p0),
    .auto_eq_value_p1(auto_eq_value_p1), .floor_pin(floor_pin),
    .eq_setting_p0(eq_setting_p0), .eq_setting_p1(eq_setting_p1),
    .auto_eq_en_p0(auto_eq_en_p0), .auto_eq_en_p1(auto_eq_en_p1),
    .auto_eq_floor_en(auto_eq_floor_en), .auto_eq_start_level_p0(auto_eq_start_level_p0),
    .auto_eq_start_level_p1(auto_eq_start_level_p1), .irq(irq));

  lieq_serializer_model link (.clk(clk), .link_locked(link_locked), .lane0_err(l0_err),
    .lane1_err(l1_err), .cw_err(cw_err));

  // ==========================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic summarize();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // bounded wait on a flag sampled at each edge; a hang ends the run
  task automatic wait_high(input bit lock);
    int n;
    n = 0;
    @(posedge clk);
    while ((lock ? rx_lock : hreadyout) !== 1'b1) begin
      n++;
      if (n > 60) begin
        fails++;
        summarize();
      end
      @(posedge clk);
    end
  endtask

  // one single word transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'h0};
    wait_high(1'b0);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    wait_high(1'b0);
    rd = hrdata;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    logic [7:0] idx [7] = '{8'h41, 8'h43, 8'h44, 8'h45, 8'h46, 8'h49, 8'h50};
    logic [7:0] ev [7] = '{8'h03, 8'h00, 8'h60, 8'h08, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, idx[i], 8'h00);
      check(rd, {24'h0, ev[i]});
    end
    check({26'h0, eq_setting_p0}, {26'h0, auto_eq_value_p0});
  endtask

  task automatic t_modes();
    for (int m = 0; m < 8; m++) begin
      bus(1'b1, 8'h43, m[7:0]);
      repeat (2) @(posedge clk);
      check({29'h0, fast_back_channel_select}, m);
      check({31'h0, fast_gpio_en}, {31'h0, m >= 1 && m <= 3});
      check({30'h0, fwd_spi_en, rev_spi_en}, {30'h0, m == 6, m == 7});
    end
  endtask

  task automatic t_eq();
    bus(1'b1, 8'h44, 8'hA5);
    repeat (3) @(posedge clk);
    check({25'h0, auto_eq_en_p0, eq_setting_p0}, 32'h2A);
    bus(1'b1, 8'h46, 8'h03);
    bus(1'b1, 8'h44, 8'h3B);
    bus(1'b1, 8'h45, 8'h05);
    repeat (3) @(posedge clk);
    check({25'h0, auto_eq_en_p1, eq_setting_p1}, 32'h0D);
    check({26'h0, eq_setting_p0}, 32'h2A);
    check({24'h0, auto_eq_start_level_p1, auto_eq_start_level_p0}, 32'h58);
    check({31'h0, auto_eq_floor_en}, 32'h1);
    bus(1'b0, 8'h44, 8'h00);
    check(rd, 32'h3B);
    bus(1'b1, 8'h46, 8'h00);
    repeat (2) @(posedge clk);
    check({31'h0, auto_eq_floor_en}, 32'h0);
    floor_pin <= 1'b1;
    repeat (4) @(posedge clk);
    check({31'h0, auto_eq_floor_en}, 32'h1);
    floor_pin <= 1'b0;
  endtask

  task automatic t_lock();
    bus(1'b1, 8'h49, 8'h03);
    link.relock();
    wait_high(1'b1);
    link.send_err(0);
    check({30'h0, rx_lock, irq}, 32'h1);
    bus(1'b0, 8'h48, 8'h00);
    check(rd, 32'h3);
    bus(1'b1, 8'h48, 8'h03);
    @(posedge clk);
    check({31'h0, irq}, 32'h0);
    bus(1'b1, 8'h41, 8'h13);
    link.relock();
    wait_high(1'b1);
    link.send_err(0);
    link.send_err(1);
    check({31'h0, rx_lock}, 32'h1);
    bus(1'b0, 8'h4A, 8'h00);
    check(rd, 32'h9);
    link.send_err(2);
    check({31'h0, rx_lock}, 32'h0);
    check(drops, 32'h2);
    bus(1'b0, 8'h4A, 8'h00);
    check(rd, 32'h2);
    check({31'h0, irq}, 32'h1);
    bus(1'b1, 8'h49, 8'h00);
    @(posedge clk);
    check({31'h0, irq}, 32'h0);
  endtask

  task automatic t_spi();
    bus(1'b1, 8'h43, 8'h17);
    repeat (6) @(posedge clk);
    check({31'h0, spi_miso_oe}, 32'h0);
    spi_ss_n <= 1'b0;
    spi_tx_bit <= 1'b1;
    spi_mosi <= 1'b1;
    repeat (6) @(posedge clk);
    check({31'h0, spi_miso_oe}, 32'h1);
    spi_sclk <= 1'b1;
    repeat (6) @(posedge clk);
    check({30'h0, spi_mosi_bit, spi_miso_o}, 32'h2);
    spi_sclk <= 1'b0;
    repeat (6) @(posedge clk);
    check({31'h0, spi_miso_o}, 32'h1);
    bus(1'b1, 8'h43, 8'h0F);
    spi_tx_bit <= 1'b0;
    spi_mosi <= 1'b0;
    spi_sclk <= 1'b1;
    repeat (6) @(posedge clk);
    check({30'h0, spi_mosi_bit, spi_miso_o}, 32'h2);
    spi_sclk <= 1'b0;
    repeat (6) @(posedge clk);
    check({31'h0, spi_mosi_bit}, 32'h0);
    spi_ss_n <= 1'b1;
    repeat (6) @(posedge clk);
    check({31'h0, spi_miso_oe}, 32'h1);
    check(samples, 32'h2);
    check(drives, 32'h2);
    bus(1'b1, 8'h43, 8'h00);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_modes();
    t_eq();
    t_lock();
    t_spi();
    summarize();
  end
endmodule
